// *** rtl/tarm_top.sv ***
// Decided for this implementation: the address map and the plain strobed port.
`timescale 1ns/1ps
// How it works
// RQ1 - Retry limit zero: a trip is never reset automatically.
// RQ2 - Nonzero limit: auto reset after trips, up to limit attempts.
// RQ3 - Wait programmed delay before auto reset; some trips wait 10 s minimum.
// RQ4 - Same code as last trip keeps counting; a different code zeroes count.
// RQ5 - Count at limit: same-code trips are no longer auto reset.
// RQ6 - Five minutes without a trip clears the retry count.
// RQ7 - Undervoltage, external, store, slot and hardware faults never auto reset.
// RQ8 - Any manual reset zeroes the retry count.
// RQ9 - Hold setting zero: healthy flag drops on every trip.
// RQ10 - Hold setting one: healthy stays up when auto reset will follow.
// RQ11 - Action bit 0 set: minor trips stop the motor first, then trip.
// RQ12 - Accumulator full: trip, or with bit 1 inhibit braking until below 95 %.
// RQ13 - Action bit 2 suppresses phase loss trip on low voltage rating only.
// RQ14 - Resistor sensor open trips unless action bit 3 is set.
// RQ15 - Nonzero user trip value acts once, then register returns to zero.
// RQ16 - User 100 resets drive, 255 clears logs, hardware codes do nothing.
// RQ17 - Other user values trip with that code unless already tripped.
// RQ18 - Rising edge of software reset bit or terminal resets the drive.
// RQ19 - Each recorded trip restarts delay and quiet timers.
// RQ20 - Auto reset clears trip and increments count in one cycle.
module tarm_top import tarm_pkg::*; #(
  parameter int unsigned TICK_CYC = `TARM_TICK_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic fault_valid,
  input wire logic [7:0] fault_code,
  input wire logic fault_minor,
  input wire logic fault_long_wait,
  input wire logic [15:0] heat_level,
  input wire logic stop_done,
  input wire logic keypad_reset,
  input wire logic rating_200v_pin,
  input wire logic phase_loss_pin,
  input wire logic resistor_open_pin,
  input wire logic reset_term_pin,
  output logic healthy_flag,
  output logic tripped,
  output logic [7:0] trip_code,
  output logic [2:0] retry_count,
  output logic stop_request,
  output logic brake_inhibit,
  output logic drive_reset_pulse,
  output logic clear_logs
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [3:0] pin_s1_r, pin_s2_r;
  logic term_d_r;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_r <= 4'h0;
      pin_s2_r <= 4'h0;
      term_d_r <= 1'b0;
    end else begin
      pin_s1_r <= {reset_term_pin, resistor_open_pin, phase_loss_pin,
                   rating_200v_pin};
      pin_s2_r <= pin_s1_r;
      term_d_r <= pin_s2_r[3];
    end
  end
  logic rated_200v, phase_loss, resistor_open, term_rise;
  assign rated_200v = pin_s2_r[0];
  assign phase_loss = pin_s2_r[1];
  assign resistor_open = pin_s2_r[2];
  assign term_rise = pin_s2_r[3] & ~term_d_r;

  ////////////////////////////////////////////////////////////////////////////
  // Register file
  logic [2:0] limit_r, limit_nxt;
  logic [7:0] delay_r, delay_nxt;
  logic hold_r, hold_nxt;
  logic [3:0] action_r, action_nxt;
  logic [7:0] inject_r, inject_nxt;
  logic swrst_r, swrst_nxt, swrst_d_r;
  logic [15:0] rdata_nxt;
  tarm_state_e state_r, state_nxt;
  logic [2:0] cnt_r, cnt_nxt;

  always_comb begin
    limit_nxt = limit_r;
    delay_nxt = delay_r;
    hold_nxt = hold_r;
    action_nxt = action_r;
    swrst_nxt = swrst_r;
    inject_nxt = 8'h00; // RQ15
    rdata_nxt = reg_rdata;
    if (reg_wr) begin
      if (reg_addr == `TARM_A_LIMIT) begin
        limit_nxt = (reg_wdata > 16'(`TARM_LIMIT_MAX)) ?
                    `TARM_LIMIT_MAX : reg_wdata[2:0];
      end else if (reg_addr == `TARM_A_DELAY) begin
        delay_nxt = (reg_wdata > 16'(`TARM_DELAY_MAX)) ?
                    `TARM_DELAY_MAX : reg_wdata[7:0];
      end else if (reg_addr == `TARM_A_HOLD) begin
        hold_nxt = reg_wdata[0];
      end else if (reg_addr == `TARM_A_ACTION) begin
        action_nxt = reg_wdata[3:0];
      end else if (reg_addr == `TARM_A_INJECT) begin
        inject_nxt = reg_wdata[7:0];
      end else if (reg_addr == `TARM_A_SWRST) begin
        swrst_nxt = reg_wdata[0];
      end
    end
    if (reg_rd) begin
      if (reg_addr == `TARM_A_LIMIT) begin
        rdata_nxt = {13'h0000, limit_r};
      end else if (reg_addr == `TARM_A_DELAY) begin
        rdata_nxt = {8'h00, delay_r};
      end else if (reg_addr == `TARM_A_HOLD) begin
        rdata_nxt = {15'h0000, hold_r};
      end else if (reg_addr == `TARM_A_ACTION) begin
        rdata_nxt = {12'h000, action_r};
      end else if (reg_addr == `TARM_A_INJECT) begin
        rdata_nxt = {8'h00, inject_r};
      end else if (reg_addr == `TARM_A_HEAT) begin
        rdata_nxt = heat_level;
      end else if (reg_addr == `TARM_A_SWRST) begin
        rdata_nxt = {15'h0000, swrst_r};
      end else if (reg_addr == `TARM_A_STATUS) begin
        rdata_nxt = {9'h000, cnt_r, 1'b0, state_r == TARM_STOP, tripped,
                     healthy_flag};
      end else if (reg_addr == `TARM_A_CODE) begin
        rdata_nxt = {8'h00, trip_code};
      end else begin
        rdata_nxt = 16'h0000;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      limit_r <= `TARM_LIMIT_RST;
      delay_r <= `TARM_DELAY_RST;
      hold_r <= `TARM_HOLD_RST;
      action_r <= `TARM_ACTION_RST;
      inject_r <= 8'h00;
      swrst_r <= 1'b0;
      swrst_d_r <= 1'b0;
      reg_rdata <= 16'h0000;
    end else begin
      limit_r <= limit_nxt;
      delay_r <= delay_nxt;
      hold_r <= hold_nxt;
      action_r <= action_nxt;
      inject_r <= inject_nxt;
      swrst_r <= swrst_nxt;
      swrst_d_r <= swrst_r;
      reg_rdata <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trip sources
  logic user_special, manual_rst;
  logic cand_valid, cand_minor, cand_long;
  tarm_code_t cand_code;
  logic heat_full;
  assign heat_full = heat_level >= `TARM_HEAT_FULL;
  assign user_special = inject_r == `TARM_USER_RESET ||
                        inject_r == `TARM_USER_CLEAR ||
                        tarm_hw_code(inject_r); // RQ16
  assign manual_rst = (swrst_r & ~swrst_d_r) | term_rise | keypad_reset |
                      (inject_r == `TARM_USER_RESET); // RQ18 RQ16

  always_comb begin
    cand_valid = 1'b1;
    cand_minor = 1'b0;
    cand_long = 1'b0;
    cand_code = 8'h00;
    if (fault_valid) begin
      cand_code = fault_code;
      cand_minor = fault_minor;
      cand_long = fault_long_wait;
    end else if (heat_full && !action_r[`TARM_ACT_BRAKE]) begin
      cand_code = `TARM_CODE_BRAKE; // RQ12
    end else if (phase_loss &&
                 !(action_r[`TARM_ACT_PHASE] && rated_200v)) begin
      cand_code = `TARM_CODE_PHASE; // RQ13
    end else if (resistor_open && !action_r[`TARM_ACT_RESISTOR]) begin
      cand_code = `TARM_CODE_RESISTOR; // RQ14
    end else if (inject_r != 8'h00 && !user_special) begin
      cand_code = inject_r; // RQ17
    end else begin
      cand_valid = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Supervisor
  logic [31:0] tick_cnt_r, tick_cnt_nxt;
  logic [11:0] dly_cnt_r, dly_cnt_nxt, quiet_r, quiet_nxt;
  tarm_code_t last_r, last_nxt, pend_r, pend_nxt;
  logic pend_long_r, pend_long_nxt, long_r, long_nxt;
  logic auto_ok_r, auto_ok_nxt;
  logic healthy_nxt, tripped_nxt, stop_nxt, inhibit_nxt, pulse_nxt;
  logic do_rec, rec_long, rec_auto, auto_fire, tick;
  tarm_code_t rec_code;
  logic [11:0] eff_dly;
  logic [2:0] base_cnt;

  assign tick = tick_cnt_r == TICK_CYC - 32'd1;
  assign eff_dly = (long_r && {4'h0, delay_r} < 12'(`TARM_LONG_TICKS)) ?
                   12'(`TARM_LONG_TICKS) : {4'h0, delay_r}; // RQ3
  assign auto_fire = state_r == TARM_TRIP && !manual_rst && auto_ok_r &&
                     dly_cnt_r >= eff_dly; // RQ2 RQ3

  always_comb begin
    tick_cnt_nxt = tick ? 32'd0 : tick_cnt_r + 32'd1;
    dly_cnt_nxt = (tick && dly_cnt_r != 12'hfff) ? dly_cnt_r + 12'd1 :
                  dly_cnt_r;
    quiet_nxt = (tick && quiet_r < 12'(`TARM_QUIET_TICKS)) ?
                quiet_r + 12'd1 : quiet_r;
    cnt_nxt = cnt_r;
    if (quiet_r >= 12'(`TARM_QUIET_TICKS)) begin
      cnt_nxt = 3'h0; // RQ6
    end
    if (manual_rst) begin
      cnt_nxt = 3'h0; // RQ8
    end
    state_nxt = state_r;
    last_nxt = last_r;
    pend_nxt = pend_r;
    pend_long_nxt = pend_long_r;
    long_nxt = long_r;
    auto_ok_nxt = auto_ok_r;
    healthy_nxt = healthy_flag;
    tripped_nxt = tripped;
    stop_nxt = 1'b0;
    pulse_nxt = manual_rst;
    do_rec = 1'b0;
    rec_code = cand_code;
    rec_long = cand_long;
    case (state_r)
      TARM_RUN: begin
        if (cand_valid && cand_minor && action_r[`TARM_ACT_STOP]) begin
          state_nxt = TARM_STOP; // RQ11
          stop_nxt = 1'b1;
          pend_nxt = cand_code;
          pend_long_nxt = cand_long;
        end else if (cand_valid) begin
          do_rec = 1'b1; // RQ11
        end
      end
      TARM_STOP: begin
        stop_nxt = !stop_done;
        if (stop_done) begin
          do_rec = 1'b1;
          rec_code = pend_r;
          rec_long = pend_long_r;
        end
      end
      TARM_TRIP: begin
        if (manual_rst || auto_fire) begin
          state_nxt = TARM_RUN;
          tripped_nxt = 1'b0;
          healthy_nxt = 1'b1;
          pulse_nxt = 1'b1;
        end
        if (auto_fire) begin
          cnt_nxt = cnt_r + 3'h1; // RQ20 RQ2
        end
      end
      default: begin
        state_nxt = TARM_RUN;
      end
    endcase
    base_cnt = (rec_code == last_r) ? cnt_nxt : 3'h0; // RQ4
    rec_auto = limit_r != 3'h0 && !tarm_no_auto(rec_code) &&
               base_cnt < limit_r; // RQ1 RQ5 RQ7
    if (do_rec) begin
      state_nxt = TARM_TRIP;
      cnt_nxt = base_cnt; // RQ4
      last_nxt = rec_code;
      long_nxt = rec_long;
      auto_ok_nxt = rec_auto;
      tripped_nxt = 1'b1;
      healthy_nxt = hold_r && rec_auto; // RQ9 RQ10
      dly_cnt_nxt = 12'h000; // RQ19
      quiet_nxt = 12'h000; // RQ19
    end
    inhibit_nxt = brake_inhibit;
    if (!action_r[`TARM_ACT_BRAKE] || heat_level < `TARM_HEAT_RELEASE) begin
      inhibit_nxt = 1'b0;
    end else if (heat_full) begin
      inhibit_nxt = 1'b1; // RQ12
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_r <= 32'd0;
      dly_cnt_r <= 12'h000;
      quiet_r <= 12'h000;
      cnt_r <= 3'h0;
      state_r <= TARM_RUN;
      last_r <= 8'h00;
      pend_r <= 8'h00;
      pend_long_r <= 1'b0;
      long_r <= 1'b0;
      auto_ok_r <= 1'b0;
      healthy_flag <= 1'b1;
      tripped <= 1'b0;
      stop_request <= 1'b0;
      brake_inhibit <= 1'b0;
      drive_reset_pulse <= 1'b0;
      clear_logs <= 1'b0;
    end else begin
      tick_cnt_r <= tick_cnt_nxt;
      dly_cnt_r <= dly_cnt_nxt;
      quiet_r <= quiet_nxt;
      cnt_r <= cnt_nxt;
      state_r <= state_nxt;
      last_r <= last_nxt;
      pend_r <= pend_nxt;
      pend_long_r <= pend_long_nxt;
      long_r <= long_nxt;
      auto_ok_r <= auto_ok_nxt;
      healthy_flag <= healthy_nxt;
      tripped <= tripped_nxt;
      stop_request <= stop_nxt;
      brake_inhibit <= inhibit_nxt;
      drive_reset_pulse <= pulse_nxt;
      clear_logs <= inject_r == `TARM_USER_CLEAR; // RQ16
    end
  end
  assign trip_code = last_r;
  assign retry_count = cnt_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_zero_limit_hold: assert property ($fell(tripped) && $past(limit_r) == 0
    |-> $past(manual_rst)) else $error("auto reset with zero limit"); // RQ1
  a_auto_count_up: assert property (auto_fire |=> !tripped &&
    cnt_r == $past(cnt_r) + 3'h1) else $error("auto reset count"); // RQ20
  a_auto_wait_min: assert property (auto_fire |-> dly_cnt_r >= delay_r &&
    (!long_r || dly_cnt_r >= 12'd100)) else $error("auto reset early"); // RQ3
  a_new_code_zero: assert property (do_rec && rec_code != last_r
    |=> cnt_r == 3'h0) else $error("count not zeroed"); // RQ4
  a_limit_stop: assert property (do_rec && rec_code == last_r &&
    cnt_nxt >= limit_r |=> !auto_ok_r) else $error("limit passed"); // RQ5
  a_quiet_clear: assert property (quiet_r >= 12'd3000 && !do_rec
    |=> cnt_r == 3'h0) else $error("quiet clear missed"); // RQ6
  a_no_auto_codes: assert property (tripped && tarm_no_auto(trip_code)
    |-> !auto_ok_r) else $error("hardware trip auto reset"); // RQ7
  a_manual_zero: assert property (manual_rst |=> cnt_r == 3'h0)
    else $error("manual reset kept count"); // RQ8
  a_healthy_drop: assert property (do_rec && !hold_r |=> !healthy_flag)
    else $error("healthy kept"); // RQ9
  a_healthy_hold: assert property (do_rec && hold_r && rec_auto
    |=> healthy_flag ##1 healthy_flag) else $error("healthy lost"); // RQ10
  a_stop_first: assert property (state_r == TARM_RUN && cand_valid &&
    cand_minor && action_r[0] |=> stop_request && !tripped)
    else $error("no stop before trip"); // RQ11
  a_brake_inhibit: assert property (action_r[1] && heat_full
    |=> brake_inhibit && !tripped || $past(tripped) || $past(fault_valid))
    else $error("brake not inhibited"); // RQ12
  a_inject_clear: assert property (inject_r != 8'h00 &&
    !(reg_wr && reg_addr == `TARM_A_INJECT) |=> inject_r == 8'h00)
    else $error("user trip not cleared"); // RQ15
  a_user_reset: assert property (inject_r == 8'h64 && tripped
    |=> !tripped && drive_reset_pulse) else $error("user reset"); // RQ16

  c_auto_reset: cover property (auto_fire ##1 !tripped);
  c_stop_path: cover property (state_r == TARM_STOP ##[1:20] tripped);
  c_user_trip: cover property (inject_r == 8'h2a ##1 tripped);
  c_quiet_clear: cover property (cnt_r != 0 ##1 quiet_r >= 12'd3000);

endmodule

// *** rtl/tarm_cfg.svh ***
`ifndef TARM_CFG_SVH
`define TARM_CFG_SVH

// Register word indices on the plain register port
`define TARM_A_LIMIT 4'h0
`define TARM_A_DELAY 4'h1
`define TARM_A_HOLD 4'h2
`define TARM_A_ACTION 4'h3
`define TARM_A_INJECT 4'h4
`define TARM_A_HEAT 4'h5
`define TARM_A_SWRST 4'h6
`define TARM_A_STATUS 4'h7
`define TARM_A_CODE 4'h8

// Reset values and limits
`define TARM_LIMIT_RST 3'h0
`define TARM_LIMIT_MAX 3'h5
`define TARM_DELAY_RST 8'h0a
`define TARM_DELAY_MAX 8'hfa
`define TARM_HOLD_RST 1'h0
`define TARM_ACTION_RST 4'h0

// Trip action field bits
`define TARM_ACT_STOP 0
`define TARM_ACT_BRAKE 1
`define TARM_ACT_PHASE 2
`define TARM_ACT_RESISTOR 3

// Status word fields
`define TARM_ST_HEALTHY 0
`define TARM_ST_TRIPPED 1
`define TARM_ST_STOPPING 2
`define TARM_ST_CNT_LSB 4

// Timing: delays count 100 ms ticks
`define TARM_CLK_NS 25
`define TARM_TICK_NS 100000000
`define TARM_TICK_CYC (`TARM_TICK_NS / `TARM_CLK_NS)
`define TARM_TICKS_PER_S (1000000000 / `TARM_TICK_NS)
`define TARM_LONG_WAIT_S 10
`define TARM_LONG_TICKS (`TARM_LONG_WAIT_S * `TARM_TICKS_PER_S)
`define TARM_QUIET_MIN 5
`define TARM_QUIET_TICKS (`TARM_QUIET_MIN * 60 * `TARM_TICKS_PER_S)

// Braking accumulator in 0.1 % units
`define TARM_HEAT_FULL 16'h03e8
`define TARM_HEAT_RELEASE 16'h03b6

// Trip codes
`define TARM_CODE_UV 8'h01
`define TARM_CODE_EEF 8'h1f
`define TARM_CODE_SLOT_A 8'hc8
`define TARM_CODE_SLOT_B 8'hcd
`define TARM_CODE_SLOT_C 8'hd2
`define TARM_CODE_HF_LO 8'hd9
`define TARM_CODE_HF_HI 8'hf5
`define TARM_CODE_EXT 8'h06
`define TARM_CODE_BRAKE 8'h13
`define TARM_CODE_RESISTOR 8'h0a
`define TARM_CODE_PHASE 8'h20
`define TARM_USER_RESET 8'h64
`define TARM_USER_CLEAR 8'hff

`endif

// *** rtl/tarm_pkg.sv ***
package tarm_pkg;
  `include "tarm_cfg.svh"

  typedef enum logic [1:0] {TARM_RUN, TARM_STOP, TARM_TRIP} tarm_state_e;
  typedef logic [7:0] tarm_code_t;

  // Hardware fault codes: no user action, never auto-reset
  function automatic logic tarm_hw_code(input tarm_code_t c);
    return c == `TARM_CODE_UV || c == `TARM_CODE_EEF ||
           c == `TARM_CODE_SLOT_A || c == `TARM_CODE_SLOT_B ||
           c == `TARM_CODE_SLOT_C ||
           (c >= `TARM_CODE_HF_LO && c <= `TARM_CODE_HF_HI);
  endfunction

  function automatic logic tarm_no_auto(input tarm_code_t c);
    return tarm_hw_code(c) || c == `TARM_CODE_EXT;
  endfunction
endpackage

// *** test/tarm_tb.sv ***
`timescale 1ns/1ps
module tb import tarm_pkg::*; ;
  `include "tarm_cfg.svh"
  typedef struct {logic w; logic [3:0] a; logic [15:0] d; logic [15:0] e;}
    tarm_row_s;
  logic clk_sys, rst_n, reg_wr, reg_rd, fault_valid, fault_minor;
  logic fault_long_wait, stop_done, keypad_reset, rating_200v_pin;
  logic phase_loss_pin, resistor_open_pin, reset_term_pin;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, heat_level, got;
  logic [7:0] fault_code, trip_code;
  logic healthy_flag, tripped, stop_request, brake_inhibit;
  logic drive_reset_pulse, clear_logs, rst_seen, clr_seen;
  logic [2:0] retry_count;
  int failures, comparisons, k;
  tarm_row_s rows[18];
  tarm_code_t rcode[6] = '{8'h30, 8'h30, 8'h31, 8'h31, 8'h31, 8'h31};
  logic [2:0] rcnt[6] = '{3'h1, 3'h2, 3'h1, 3'h2, 3'h3, 3'h3};
  logic rauto[6] = '{1, 1, 1, 1, 1, 0};
  tarm_code_t hw[8] = '{8'h06, 8'h01, 8'h1f, 8'hc8, 8'hcd, 8'hd2, 8'hd9,
    8'hf5};

  tarm_top #(.TICK_CYC(4)) dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fault_valid(fault_valid),
    .fault_code(fault_code), .fault_minor(fault_minor),
    .fault_long_wait(fault_long_wait), .heat_level(heat_level),
    .stop_done(stop_done), .keypad_reset(keypad_reset),
    .rating_200v_pin(rating_200v_pin), .phase_loss_pin(phase_loss_pin),
    .resistor_open_pin(resistor_open_pin), .reset_term_pin(reset_term_pin),
    .healthy_flag(healthy_flag), .tripped(tripped), .trip_code(trip_code),
    .retry_count(retry_count), .stop_request(stop_request),
    .brake_inhibit(brake_inhibit), .drive_reset_pulse(drive_reset_pulse),
    .clear_logs(clear_logs));

  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // Latch one-cycle pulses for later checks
  always @(posedge drive_reset_pulse) rst_seen <= 1'b1;
  always @(posedge clear_logs) clr_seen <= 1'b1;

  initial begin
    #750000;
    failures++;
    results();
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] g);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    g = reg_rdata;
  endtask

  task automatic trip(input tarm_code_t c, input logic lw, input logic mn);
    @(posedge clk_sys);
    fault_valid <= 1'b1;
    fault_code <= c;
    fault_long_wait <= lw;
    fault_minor <= mn;
    @(posedge clk_sys);
    fault_valid <= 1'b0;
    fault_long_wait <= 1'b0;
    fault_minor <= 1'b0;
  endtask

  task automatic wt(input logic v, input int n);
    k = 0;
    #1;
    while (tripped !== v && k < n) begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    chk("tripped", 16'(v), 16'(tripped));
  endtask

  task automatic stay(input logic v, input int n);
    int bad;
    bad = 0;
    repeat (n) begin
      @(posedge clk_sys);
      #1;
      if (tripped !== v) bad++;
    end
    chk("tripped held", 16'h0000, 16'(bad));
  endtask

  task automatic mrst();
    @(posedge clk_sys);
    keypad_reset <= 1'b1;
    @(posedge clk_sys);
    keypad_reset <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask

  task automatic results();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n, reg_wr, reg_rd, fault_valid, fault_minor, fault_long_wait} = '0;
    {stop_done, keypad_reset, rating_200v_pin, phase_loss_pin} = '0;
    {resistor_open_pin, reset_term_pin, rst_seen, clr_seen} = '0;
    reg_addr = '0;
    reg_wdata = '0;
    fault_code = '0;
    heat_level = 16'h0123;
    rows = '{'{0, `TARM_A_LIMIT, 0, 0}, '{0, `TARM_A_DELAY, 0, 10},
      '{0, `TARM_A_HOLD, 0, 0}, '{0, `TARM_A_ACTION, 0, 0},
      '{0, `TARM_A_INJECT, 0, 0}, '{0, `TARM_A_SWRST, 0, 0},
      '{0, `TARM_A_STATUS, 0, 1}, '{0, `TARM_A_CODE, 0, 0},
      '{0, `TARM_A_HEAT, 0, 16'h0123}, '{1, `TARM_A_LIMIT, 8, 5},
      '{1, `TARM_A_LIMIT, 3, 3}, '{1, `TARM_A_DELAY, 16'h00ff, 250},
      '{1, `TARM_A_DELAY, 2, 2}, '{1, `TARM_A_HOLD, 1, 1},
      '{1, `TARM_A_ACTION, 15, 15}, '{1, `TARM_A_ACTION, 0, 0},
      '{1, 4'h9, 16'h0055, 0}, '{1, `TARM_A_HEAT, 16'h0077, 16'h0123}};
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      rd(rows[i].a, got);
      chk("register", rows[i].e, got);
    end
    heat_level <= 16'h0000;
    $display("test registers done");
    foreach (rcode[i]) begin
      rst_seen = 1'b0;
      trip(rcode[i], 1'b0, 1'b0);
      repeat (2) @(posedge clk_sys);
      #1;
      chk("healthy", 16'(rauto[i]), 16'(healthy_flag));
      if (rauto[i]) begin
        stay(1'b1, 3);
        wt(1'b0, 12);
        chk("reset pulse", 16'h0001, 16'(rst_seen));
      end else begin
        stay(1'b1, 30);
      end
      chk("count", 16'(rcnt[i]), 16'(retry_count));
    end
    mrst();
    chk("count", 16'h0000, 16'(retry_count));
    $display("test retry done");
    trip(8'h30, 1'b0, 1'b0);
    wt(1'b0, 20);
    repeat (12100) @(posedge clk_sys);
    #1;
    chk("quiet count", 16'h0000, 16'(retry_count));
    trip(8'h30, 1'b1, 1'b0);
    stay(1'b1, 380);
    wt(1'b0, 40);
    $display("test quiet and long wait done");
    foreach (hw[i]) begin
      trip(hw[i], 1'b0, 1'b0);
      stay(1'b1, 30);
      chk("healthy", 16'h0000, 16'(healthy_flag));
      mrst();
    end
    $display("test no auto codes done");
    wr(`TARM_A_HOLD, 0);
    trip(8'h41, 1'b0, 1'b0);
    repeat (2) @(posedge clk_sys);
    #1;
    chk("healthy", 16'h0000, 16'(healthy_flag));
    wt(1'b0, 20);
    wr(`TARM_A_LIMIT, 0);
    trip(8'h41, 1'b0, 1'b0);
    stay(1'b1, 30);
    rst_seen = 1'b0;
    reset_term_pin <= 1'b1;
    wt(1'b0, 8);
    chk("reset pulse", 16'h0001, 16'(rst_seen));
    reset_term_pin <= 1'b0;
    trip(8'h44, 1'b0, 1'b0);
    wt(1'b1, 5);
    wr(`TARM_A_SWRST, 1);
    wr(`TARM_A_SWRST, 0);
    wt(1'b0, 8);
    $display("test manual reset done");
    wr(`TARM_A_ACTION, 1);
    trip(8'h50, 1'b0, 1'b1);
    repeat (2) @(posedge clk_sys);
    #1;
    chk("stop request", 16'h0001, 16'(stop_request));
    stay(1'b0, 4);
    stop_done <= 1'b1;
    wt(1'b1, 5);
    stop_done <= 1'b0;
    chk("trip code", 16'h0050, 16'(trip_code));
    mrst();
    wr(`TARM_A_ACTION, 0);
    heat_level <= `TARM_HEAT_FULL;
    wt(1'b1, 10);
    chk("trip code", 16'(`TARM_CODE_BRAKE), 16'(trip_code));
    heat_level <= 16'h0000;
    mrst();
    wr(`TARM_A_ACTION, 2);
    heat_level <= `TARM_HEAT_FULL;
    stay(1'b0, 4);
    chk("inhibit", 16'h0001, 16'(brake_inhibit));
    heat_level <= 16'd960;
    stay(1'b0, 3);
    chk("inhibit", 16'h0001, 16'(brake_inhibit));
    heat_level <= 16'd949;
    stay(1'b0, 3);
    chk("inhibit", 16'h0000, 16'(brake_inhibit));
    heat_level <= 16'h0000;
    $display("test stop and braking done");
    wr(`TARM_A_ACTION, 4);
    rating_200v_pin <= 1'b1;
    phase_loss_pin <= 1'b1;
    stay(1'b0, 8);
    rating_200v_pin <= 1'b0;
    wt(1'b1, 10);
    chk("trip code", 16'(`TARM_CODE_PHASE), 16'(trip_code));
    phase_loss_pin <= 1'b0;
    mrst();
    wr(`TARM_A_ACTION, 8);
    resistor_open_pin <= 1'b1;
    stay(1'b0, 8);
    wr(`TARM_A_ACTION, 0);
    wt(1'b1, 10);
    chk("trip code", 16'(`TARM_CODE_RESISTOR), 16'(trip_code));
    resistor_open_pin <= 1'b0;
    mrst();
    $display("test pins done");
    wr(`TARM_A_INJECT, 16'h0042);
    wt(1'b1, 5);
    rd(`TARM_A_INJECT, got);
    chk("inject", 16'h0000, got);
    wr(`TARM_A_INJECT, 16'h0043);
    stay(1'b1, 3);
    chk("trip code", 16'h0042, 16'(trip_code));
    rst_seen = 1'b0;
    wr(`TARM_A_INJECT, 16'(`TARM_USER_RESET));
    wt(1'b0, 5);
    chk("reset pulse", 16'h0001, 16'(rst_seen));
    wr(`TARM_A_INJECT, 16'(`TARM_USER_CLEAR));
    stay(1'b0, 3);
    chk("clear logs", 16'h0001, 16'(clr_seen));
    for (int i = 1; i < 8; i++) begin
      wr(`TARM_A_INJECT, 16'(hw[i]));
      stay(1'b0, 4);
    end
    $display("test user trip done");
    results();
  end
endmodule
